// File: hdl/wolf_defs.vh
/*
 * Constants of the wake-on-LAN receive filter: register indices, field positions,
 * reset values and wake pulse timing.
 * Assumes the includer uses them with 16-bit register fields and a 32-bit bus.
 */
`ifndef WOLF_DEFS_VH
`define WOLF_DEFS_VH

// ****************************************************************
// register indices, byte address is four times the index
// ****************************************************************
`define WOLF_IDX_CFG 12'h134
`define WOLF_IDX_FLAGS 12'h135
`define WOLF_IDX_STA0 12'h136
`define WOLF_IDX_STA1 12'h137
`define WOLF_IDX_STA2 12'h138
`define WOLF_IDX_PW0 12'h139
`define WOLF_IDX_PW1 12'h13A
`define WOLF_IDX_PW2 12'h13B
`define WOLF_IDX_PAT0 12'h13C
`define WOLF_IDX_PAT1 12'h13D
`define WOLF_IDX_PAT2 12'h13E
`define WOLF_IDX_PAT3 12'h13F
`define WOLF_IDX_IRQ_STS 12'h150
`define WOLF_IDX_IRQ_CLR 12'h151
`define WOLF_IDX_IRQ_EN 12'h152

// ****************************************************************
// configuration register fields
// ****************************************************************
`define WOLF_CFG_CLEAR 11
`define WOLF_CFG_LEN_HI 10
`define WOLF_CFG_LEN_LO 9
`define WOLF_CFG_STYLE 8
`define WOLF_CFG_EXT 7
`define WOLF_CFG_PW_EN 5
`define WOLF_CFG_UCAST 4
`define WOLF_CFG_BCAST 2
`define WOLF_CFG_PAT 1
`define WOLF_CFG_MAGIC 0
`define WOLF_CFG_RESET 16'h0004
`define WOLF_CFG_WMASK 16'h07B7

// ****************************************************************
// flag bits, shared by the flag register and the interrupt registers
// ****************************************************************
`define WOLF_FLG_SFD 7
`define WOLF_FLG_CRC 6
`define WOLF_FLG_HACK 5
`define WOLF_FLG_UCAST 4
`define WOLF_FLG_BCAST 2
`define WOLF_FLG_PAT 1
`define WOLF_FLG_MAGIC 0

// ****************************************************************
// timing: wake pulse lengths are given in periods of the 125 MHz clock
// ****************************************************************
`define WOLF_FAST_PERIOD_NS 8
`define WOLF_MCLK_PERIOD_NS 40
`define WOLF_LEN0_FAST 8
`define WOLF_LEN1_FAST 16
`define WOLF_LEN2_FAST 32
`define WOLF_LEN3_FAST 64

`endif

// File: hdl/wolf_pulse.v
/*
 * Wake output shaper: turns a one-cycle wake event into a pulse or a held level.
 * Assumes MCLK at 25 MHz; pulse lengths in fast-clock periods are rounded up.
 */
`timescale 1ns/1ns
`default_nettype none
`include "wolf_defs.vh"

module wolf_pulse (
    input wire clk,
    input wire rst_n,
    input wire fire,
    input wire level_style,
    input wire clear,
    input wire [1:0] len_sel,
    output reg wake_r
);

    reg [3:0] cnt_r;

    // ****************************************************************
    // length in fast periods converted to MCLK cycles, rounded up
    // ****************************************************************
    function [3:0] len_cycles;
        input [1:0] sel;
        reg [31:0] fast;
        reg [31:0] cyc;
        begin
            case (sel)
                2'h0: fast = `WOLF_LEN0_FAST;
                2'h1: fast = `WOLF_LEN1_FAST;
                2'h2: fast = `WOLF_LEN2_FAST;
                default: fast = `WOLF_LEN3_FAST;
            endcase
            cyc = (fast * `WOLF_FAST_PERIOD_NS + `WOLF_MCLK_PERIOD_NS - 1)
                / `WOLF_MCLK_PERIOD_NS;
            len_cycles = cyc[3:0]; // longest pulse is 13 cycles, fits four bits
        end
    endfunction

    // pulse counts down, level holds until cleared; a new event wins over clear
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_r <= 1'b0;
            cnt_r <= 4'h0;
        end else if (fire) begin
            wake_r <= 1'b1; // [RL12]
            cnt_r <= len_cycles(len_sel); // [RL2]
        end else if (level_style) begin
            cnt_r <= 4'h0;
            if (clear) begin
                wake_r <= 1'b0; // [RL1]
            end
        end else if (cnt_r > 4'h1) begin
            cnt_r <= cnt_r - 4'h1; // [RL3]
        end else begin
            cnt_r <= 4'h0;
            wake_r <= 1'b0; // [RL2]
        end
    end

endmodule // wolf_pulse

`default_nettype wire

// File: hdl/wolf_filter.v
/*
 * Wake-on-LAN receive filter with AHB-Lite register slave.
 * Assumes the receive byte stream and frame strobes come from logic on MCLK.
 * Station, password and pattern bytes are packed with byte 0 in the low bits.
 * Flags, irq status and irq enable share one bit layout.
 */
// What this block does
// [RL1] Writing one to config bit 11 drops a held wake level; bit self-clears.
// [RL2] Pulse length field picks 8, 16, 32 or 64 fast-clock periods.
// [RL3] Style bit 8: one holds a level, zero gives one timed pulse.
// [RL4] Bit 7 enables wake detection, CRC checking and frame indications.
// [RL5] Bit 5 makes magic packets need the matching password.
// [RL6] Bit 4 lets valid unicast frames raise an interrupt.
// [RL7] Bit 2 lets valid broadcast frames raise an interrupt; resets to one.
// [RL8] Bit 1 lets frames matching the byte pattern raise an interrupt.
// [RL9] Bit 0 lets valid magic packets raise an interrupt.
// [RL10] Flag register latches each receive event and clears when read.
// [RL11] 48-bit password over three registers; with bit 5 set, a mismatch sets the hack flag.
// [RL12] Any enabled event, with bit 7 set, drives the wake output.
`timescale 1ns/1ns
`default_nettype none
`include "wolf_defs.vh"

module wolf_filter (
    input wire MCLK,
    input wire RST_N,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output reg [31:0] HRDATA,
    output reg HREADYOUT,
    output reg HRESP,
    input wire RX_SOF,
    input wire RX_BYTE_VALID,
    input wire [7:0] RX_BYTE,
    input wire RX_EOF,
    input wire RX_CRC_OK,
    input wire RX_FRAME_START_ERROR_FLAG,
    output reg IRQ,
    output wire WAKE
);

    // register file, bus capture and parser state
    reg [15:0] cfg_r;
    reg [7:0] flags_r;
    reg [47:0] sta_r;
    reg [47:0] pw_r;
    reg [63:0] pat_r;
    reg [7:0] irq_sts_r;
    reg [7:0] irq_en_r;
    reg wr_pend_r;
    reg rd_pend_r;
    reg [11:0] idx_r;
    reg [3:0] bc_r;
    reg ucast_ok_r;
    reg bcast_ok_r;
    reg pat_ok_r;
    reg [2:0] ff_cnt_r;
    reg [2:0] mg_idx_r;
    reg [3:0] mg_rep_r;
    reg mg_hit_r;
    reg [2:0] pw_idx_r;
    reg pw_ok_r;
    reg clear_r;
    // extended enable and address phase decode
    wire ext = cfg_r[`WOLF_CFG_EXT];
    wire addr_take = HSEL && HREADY && HTRANS[1];
    wire [11:0] addr_idx = HADDR[13:2];
    wire rd_flags = rd_pend_r && (idx_r == `WOLF_IDX_FLAGS);

    // ****************************************************************
    // byte pick from a packed vector, byte 0 in the low bits
    // ****************************************************************
    function [7:0] byte_of;
        input [63:0] v;
        input [2:0] i;
        begin
            byte_of = v[i * 8 +: 8];
        end
    endfunction

    // ****************************************************************
    // frame parser
    // ****************************************************************
    // magic sequence compares against the station byte at mg_idx_r
    wire [7:0] sta_b = byte_of({16'h0000, sta_r}, mg_idx_r);
    wire rx_b = ext && RX_BYTE_VALID; // [RL4]

    // destination, pattern and magic sequence checks per received byte
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            bc_r <= 4'h0;
            ucast_ok_r <= 1'b0;
            bcast_ok_r <= 1'b0;
            pat_ok_r <= 1'b0;
            ff_cnt_r <= 3'h0;
            mg_idx_r <= 3'h0;
            mg_rep_r <= 4'h0;
            mg_hit_r <= 1'b0;
            pw_idx_r <= 3'h0;
            pw_ok_r <= 1'b0;
        end else if (RX_SOF) begin
            bc_r <= 4'h0;
            ucast_ok_r <= 1'b1;
            bcast_ok_r <= 1'b1;
            pat_ok_r <= 1'b1;
            ff_cnt_r <= 3'h0;
            mg_idx_r <= 3'h0;
            mg_rep_r <= 4'h0;
            mg_hit_r <= 1'b0;
            pw_idx_r <= 3'h0;
            pw_ok_r <= 1'b1;
        end else if (rx_b) begin
            if (bc_r != 4'hF) begin
                bc_r <= bc_r + 4'h1;
            end
            if (bc_r < 4'h6) begin
                ucast_ok_r <= ucast_ok_r && (RX_BYTE == byte_of({16'h0000, sta_r}, bc_r[2:0]));
                bcast_ok_r <= bcast_ok_r && (RX_BYTE == 8'hFF);
            end
            if (bc_r < 4'h8) begin
                pat_ok_r <= pat_ok_r && (RX_BYTE == byte_of(pat_r, bc_r[2:0])); // [RL8]
            end
            if (mg_hit_r) begin
                if (pw_idx_r < 3'h6) begin
                    pw_idx_r <= pw_idx_r + 3'h1;
                    pw_ok_r <= pw_ok_r && (RX_BYTE == byte_of({16'h0000, pw_r}, pw_idx_r));
                end
            end else if (ff_cnt_r < 3'h6) begin
                ff_cnt_r <= (RX_BYTE == 8'hFF) ? ff_cnt_r + 3'h1 : 3'h0;
            end else if (RX_BYTE == sta_b) begin
                if (mg_idx_r == 3'h5) begin
                    mg_idx_r <= 3'h0;
                    mg_rep_r <= mg_rep_r + 4'h1;
                    if (mg_rep_r == 4'hF) begin
                        mg_hit_r <= 1'b1; // [RL9]
                    end
                end else begin
                    mg_idx_r <= mg_idx_r + 3'h1;
                end
            end else if (!(RX_BYTE == 8'hFF && mg_idx_r == 3'h0 && mg_rep_r == 4'h0)) begin
                ff_cnt_r <= (RX_BYTE == 8'hFF) ? 3'h1 : 3'h0;
                mg_idx_r <= 3'h0;
                mg_rep_r <= 4'h0;
            end
        end
    end

    // ****************************************************************
    // end-of-frame decisions
    // ****************************************************************
    // frame verdicts, valid only in the cycle of RX_EOF, except ev_sfd which follows RX_FRAME_START_ERROR_FLAG
    wire eof = ext && RX_EOF; // [RL4]
    wire good = eof && RX_CRC_OK;
    wire pw_match = (pw_idx_r == 3'h6) && pw_ok_r;
    wire pw_need = cfg_r[`WOLF_CFG_PW_EN];
    wire ev_magic = good && mg_hit_r && (!pw_need || pw_match); // [RL5]
    wire ev_hack = good && mg_hit_r && pw_need && !pw_match; // [RL11]
    wire ev_pat = good && pat_ok_r && (bc_r >= 4'h8);
    wire ev_bcast = good && bcast_ok_r && (bc_r >= 4'h6);
    wire ev_ucast = good && ucast_ok_r && !bcast_ok_r && (bc_r >= 4'h6);
    wire ev_crc = eof && !RX_CRC_OK; // [RL4]
    wire ev_sfd = ext && RX_FRAME_START_ERROR_FLAG;
    wire [7:0] ev_all = {ev_sfd, ev_crc, ev_hack, ev_ucast, 1'b0, ev_bcast, ev_pat, ev_magic};
    // interrupt events: wake events gated by their enables, errors always
    wire [7:0] ev_irq = {ev_sfd, ev_crc, ev_hack,
        ev_ucast && cfg_r[`WOLF_CFG_UCAST], // [RL6]
        1'b0,
        ev_bcast && cfg_r[`WOLF_CFG_BCAST], // [RL7]
        ev_pat && cfg_r[`WOLF_CFG_PAT], // [RL8]
        ev_magic && cfg_r[`WOLF_CFG_MAGIC]}; // [RL9]
    wire wake_fire = |ev_irq[4:0]; // [RL12]

    // ****************************************************************
    // AHB-Lite slave: writes complete with no wait, reads take one wait
    // ****************************************************************
    // address phase capture; a read holds ready low for one cycle
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            idx_r <= 12'h000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HRESP <= 1'b0;
            if (rd_pend_r) begin
                rd_pend_r <= 1'b0;
                HREADYOUT <= 1'b1;
            end else begin
                wr_pend_r <= addr_take && HWRITE;
                rd_pend_r <= addr_take && !HWRITE;
                HREADYOUT <= !(addr_take && !HWRITE);
                if (addr_take) begin
                    idx_r <= addr_idx;
                end
            end
        end
    end

    // read data selected in the wait cycle so a preceding write is seen
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            HRDATA <= 32'h00000000;
        end else if (rd_pend_r) begin
            case (idx_r)
                `WOLF_IDX_CFG: HRDATA <= {16'h0000, cfg_r};
                `WOLF_IDX_FLAGS: HRDATA <= {24'h000000, flags_r};
                `WOLF_IDX_STA0: HRDATA <= {16'h0000, sta_r[15:0]};
                `WOLF_IDX_STA1: HRDATA <= {16'h0000, sta_r[31:16]};
                `WOLF_IDX_STA2: HRDATA <= {16'h0000, sta_r[47:32]};
                `WOLF_IDX_PW0: HRDATA <= {16'h0000, pw_r[15:0]};
                `WOLF_IDX_PW1: HRDATA <= {16'h0000, pw_r[31:16]};
                `WOLF_IDX_PW2: HRDATA <= {16'h0000, pw_r[47:32]};
                `WOLF_IDX_PAT0: HRDATA <= {16'h0000, pat_r[15:0]};
                `WOLF_IDX_PAT1: HRDATA <= {16'h0000, pat_r[31:16]};
                `WOLF_IDX_PAT2: HRDATA <= {16'h0000, pat_r[47:32]};
                `WOLF_IDX_PAT3: HRDATA <= {16'h0000, pat_r[63:48]};
                `WOLF_IDX_IRQ_STS: HRDATA <= {24'h000000, irq_sts_r};
                `WOLF_IDX_IRQ_EN: HRDATA <= {24'h000000, irq_en_r};
                default: HRDATA <= 32'h00000000;
            endcase
        end
    end

    // ****************************************************************
    // register writes
    // ****************************************************************
    wire wr_cfg = wr_pend_r && (idx_r == `WOLF_IDX_CFG);

    // config, address, password and pattern storage
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_r <= `WOLF_CFG_RESET; // [RL7]
            sta_r <= 48'h000000000000;
            pw_r <= 48'h000000000000;
            pat_r <= 64'h0000000000000000;
            irq_en_r <= 8'h00;
            clear_r <= 1'b0;
        end else begin
            // clear bit reads back zero, only a one-cycle pulse is kept
            clear_r <= wr_cfg && HWDATA[`WOLF_CFG_CLEAR] && cfg_r[`WOLF_CFG_STYLE]; // [RL1]
            if (wr_cfg) begin
                cfg_r <= HWDATA[15:0] & `WOLF_CFG_WMASK;
            end
            if (wr_pend_r) begin
                case (idx_r)
                    `WOLF_IDX_STA0: sta_r[15:0] <= HWDATA[15:0];
                    `WOLF_IDX_STA1: sta_r[31:16] <= HWDATA[15:0];
                    `WOLF_IDX_STA2: sta_r[47:32] <= HWDATA[15:0];
                    `WOLF_IDX_PW0: pw_r[15:0] <= HWDATA[15:0]; // [RL11]
                    `WOLF_IDX_PW1: pw_r[31:16] <= HWDATA[15:0]; // [RL11]
                    `WOLF_IDX_PW2: pw_r[47:32] <= HWDATA[15:0]; // [RL11]
                    `WOLF_IDX_PAT0: pat_r[15:0] <= HWDATA[15:0];
                    `WOLF_IDX_PAT1: pat_r[31:16] <= HWDATA[15:0];
                    `WOLF_IDX_PAT2: pat_r[47:32] <= HWDATA[15:0];
                    `WOLF_IDX_PAT3: pat_r[63:48] <= HWDATA[15:0];
                    `WOLF_IDX_IRQ_EN: irq_en_r <= HWDATA[7:0] & 8'hF7;
                    default: ;
                endcase
            end
        end
    end

    // ****************************************************************
    // flags and interrupt; a new event wins over a clear
    // ****************************************************************
    wire wr_iclr = wr_pend_r && (idx_r == `WOLF_IDX_IRQ_CLR);

    // sticky flags and irq status, irq level registered
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            flags_r <= 8'h00;
            irq_sts_r <= 8'h00;
            IRQ <= 1'b0;
        end else begin
            flags_r <= (rd_flags ? 8'h00 : flags_r) | ev_all; // [RL10]
            irq_sts_r <= (irq_sts_r & ~(wr_iclr ? HWDATA[7:0] : 8'h00)) | ev_irq;
            IRQ <= |(irq_sts_r & irq_en_r);
        end
    end

    // ****************************************************************
    // wake output shaping
    // ****************************************************************
    wolf_pulse u_pulse (
        .clk(MCLK),
        .rst_n(RST_N),
        .fire(wake_fire),
        .level_style(cfg_r[`WOLF_CFG_STYLE]), // [RL3]
        .clear(clear_r),
        .len_sel(cfg_r[`WOLF_CFG_LEN_HI:`WOLF_CFG_LEN_LO]),
        .wake_r(WAKE)
    );

endmodule // wolf_filter

`default_nettype wire

// File: tb/wolf_props.sv
/* checker of the wake filter ports: bus timing, wake shape, irq cause.
   assumes HREADY is tied to HREADYOUT and the config holds wake style */
`timescale 1ns/1ns
`default_nettype none
`include "wolf_defs.vh"
module wolf_props (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic RX_EOF,
    input wire logic RX_FRAME_START_ERROR_FLAG,
    input wire logic IRQ,
    input wire logic WAKE
);
    // ********************************
    // helper state
    // ********************************
    logic phase_r, wr_r, style_r, ext_r;
    logic [11:0] idx_r;
    logic [1:0] len_r;
    logic [4:0] cnt_r;
    // data phase decode of config and irq enable writes
    wire dp_wr = phase_r & wr_r & HREADY;
    wire cfg_wr = dp_wr & (idx_r == `WOLF_IDX_CFG);
    wire en_wr = dp_wr & (idx_r == `WOLF_IDX_IRQ_EN);
    wire rx_ev = RX_EOF | RX_FRAME_START_ERROR_FLAG;
    wire [4:0] plen = (len_r == 2'h0) ? 5'h02 : (len_r == 2'h1) ? 5'h04 :
        (len_r == 2'h2) ? 5'h07 : 5'h0D;
    // follow address phases, config fields and wake high time
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            phase_r <= 1'b0;
            wr_r <= 1'b0;
            idx_r <= 12'h000;
            style_r <= 1'b0;
            ext_r <= 1'b0;
            len_r <= 2'h0;
            cnt_r <= 5'h00;
        end else begin
            if (HREADY) begin
                phase_r <= HSEL & HTRANS[1];
                wr_r <= HWRITE;
                idx_r <= HADDR[13:2];
            end
            if (cfg_wr) begin
                style_r <= HWDATA[`WOLF_CFG_STYLE];
                ext_r <= HWDATA[`WOLF_CFG_EXT];
                len_r <= HWDATA[`WOLF_CFG_LEN_HI:`WOLF_CFG_LEN_LO];
            end
            cnt_r <= WAKE ? cnt_r + 5'h01 : 5'h00;
        end
    end
    // ********************************
    // properties
    // ********************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    sequence s_rd_req;
        HSEL && HREADY && HTRANS[1] && !HWRITE;
    endsequence
    sequence s_one_wait;
        !HREADYOUT ##1 HREADYOUT;
    endsequence
    a_resp_okay: assert property (HRESP == 1'b0)
        else $error("bus response not okay");
    a_read_wait: assert property (s_rd_req |=> s_one_wait)
        else $error("read not one wait state");
    a_write_nowait: assert property (HSEL && HREADY && HTRANS[1] && HWRITE |=> HREADYOUT)
        else $error("write was stalled");
    a_rdata_hold: assert property (!$rose(HREADYOUT) |-> $stable(HRDATA))
        else $error("read data moved outside a read");
    a_wake_cause: assert property ($rose(WAKE) |-> $past(RX_EOF) && ext_r)
        else $error("wake rose without frame end");
    a_pulse_len: assert property ($fell(WAKE) && !style_r |-> cnt_r == plen)
        else $error("wake pulse length wrong");
    a_level_clear: assert property (cfg_wr && HWDATA[11] && HWDATA[8] && style_r
        |-> ##[1:3] !WAKE)
        else $error("held wake not cleared");
    a_level_hold: assert property ($fell(WAKE) && style_r
        |-> $past(cfg_wr) || $past(cfg_wr, 2) || $past(cfg_wr, 3))
        else $error("held wake dropped by itself");
    a_irq_cause: assert property ($rose(IRQ) |-> $past(rx_ev, 2) || $past(en_wr, 2))
        else $error("irq rose without cause");
endmodule // wolf_props
bind wolf_filter wolf_props u_props (
    .MCLK(MCLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RX_EOF(RX_EOF), .RX_FRAME_START_ERROR_FLAG(RX_FRAME_START_ERROR_FLAG),
    .IRQ(IRQ), .WAKE(WAKE)
);
`default_nettype wire

// File: tb/wolf_rx_model.sv
/* frame source standing for the remote station on the receive byte stream.
   assumes tasks are entered just after a rising clock edge */
`timescale 1ns/1ns
`default_nettype none
module wolf_rx_model (
    input wire logic clk,
    output logic sof,
    output logic vld,
    output logic [7:0] dat,
    output logic eof,
    output logic crc_ok,
    output logic frame_start_error_flag
);
    // ********************************
    // idle lines and frame tasks
    // ********************************
    initial begin
        sof = 1'b0;
        vld = 1'b0;
        dat = 8'h5A;
        eof = 1'b0;
        crc_ok = 1'b0;
        frame_start_error_flag = 1'b0;
    end
    // one frame, optional idle gap after each byte
    task automatic send(input logic [7:0] q[$], input logic good, input int gap);
        sof <= 1'b1;
        @(posedge clk);
        sof <= 1'b0;
        foreach (q[i]) begin
            vld <= 1'b1;
            dat <= q[i];
            @(posedge clk);
            if (gap > 0) begin
                vld <= 1'b0;
                dat <= ~q[i]; // released byte does not keep its value
                repeat (gap) @(posedge clk);
            end
        end
        vld <= 1'b0;
        dat <= ~dat;
        eof <= 1'b1;
        crc_ok <= good;
        @(posedge clk);
        eof <= 1'b0;
        crc_ok <= ~good;
    endtask
    // frame with a broken start delimiter
    task automatic sfd;
        frame_start_error_flag <= 1'b1;
        @(posedge clk);
        frame_start_error_flag <= 1'b0;
    endtask
endmodule // wolf_rx_model
`default_nettype wire

// File: tb/wolf_filter_tb_top.sv
/* testbench of the wake filter: bus tasks, frame cases, verdict.
   assumes the frame source model and the bound checker */
`timescale 1ns/1ns
`default_nettype none
`define CHK(A, E) begin checks++; if ((A) !== (E)) begin error_cnt++; \
    $display("wrong value t=%0t got %h exp %h", $time, A, E); end end
module wolf_filter_tb_top;
    // ********************************
    // signals and instances
    // ********************************
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] v;
    logic [7:0] fq[$];
    logic [7:0] st[6] = '{8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
    logic [15:0] rv[10] = '{16'h1102, 16'h3322, 16'h5544, 16'hA1A0, 16'hA3A2,
        16'hA5A4, 16'h1110, 16'h1312, 16'h1514, 16'h1716};
    int plen[4] = '{2, 4, 7, 13};
    int error_cnt = 0;
    int checks = 0;
    int gap_v = 0;
    wire logic [31:0] hrdata;
    wire logic [7:0] rx_byte;
    wire logic hreadyout, hresp, irq, wake, sof, vld, eof, crc_ok, frame_start_error_flag;
    initial forever #20 mclk = ~mclk;
    wolf_filter uut (
        .MCLK(mclk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .RX_SOF(sof),
        .RX_BYTE_VALID(vld), .RX_BYTE(rx_byte), .RX_EOF(eof), .RX_CRC_OK(crc_ok),
        .RX_FRAME_START_ERROR_FLAG(frame_start_error_flag), .IRQ(irq), .WAKE(wake)
    );
    wolf_rx_model rx (
        .clk(mclk), .sof(sof), .vld(vld), .dat(rx_byte), .eof(eof),
        .crc_ok(crc_ok), .frame_start_error_flag(frame_start_error_flag)
    );
    // ********************************
    // tasks
    // ********************************
    task automatic results;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // bounded wait for ready sampled high
    task automatic rdy;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            error_cnt++;
            results();
        end
    endtask
    // one single word transfer, read data left in v
    task automatic xfer(input logic w, input logic [11:0] i, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {18'h0, i, 2'h0};
        rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        v = hrdata;
    endtask
    task automatic rchk(input logic [11:0] i, input logic [31:0] e);
        xfer(1'b0, i, 32'h0);
        `CHK(v, e)
    endtask
    // frame kinds: 0 broadcast, 1 unicast, 2 pattern, 3 magic, 4 magic bad password
    task automatic build(input int k);
        fq.delete();
        if (k == 1) begin
            foreach (st[j]) fq.push_back(st[j]);
        end else if (k == 2) begin
            for (int j = 0; j < 8; j++) fq.push_back(8'h10 + 8'(j));
        end else begin
            repeat (6) fq.push_back(k > 2 ? 8'h0A : 8'hFF);
        end
        if (k > 2) begin
            repeat (6) fq.push_back(8'hFF);
            repeat (16) foreach (st[j]) fq.push_back(st[j]);
            for (int j = 0; j < 6; j++) fq.push_back(k == 3 ? 8'hA0 + 8'(j) : 8'h5A);
        end
        repeat (4) fq.push_back(8'h3C);
    endtask
    // config, frame, then wake cycles, irq status, flags and read clear
    task automatic case_run(input logic [15:0] c, input int k, input logic crc,
        input logic [7:0] m, input logic [7:0] e, input int w);
        int n;
        logic [7:0] s;
        n = 0;
        s = e & m & (8'hE0 | (c[7:0] & 8'h17));
        xfer(1'b1, 12'h134, {16'h0, c});
        build(k);
        if (k == 5) begin
            rx.sfd();
        end else begin
            rx.send(fq, crc, gap_v);
        end
        repeat (20) begin
            @(posedge mclk);
            if (wake !== 1'b0) n++;
        end
        xfer(1'b0, 12'h150, 32'h0);
        `CHK(v[7:0] & m, s)
        `CHK(irq, |s)
        xfer(1'b0, 12'h135, 32'h0);
        `CHK(v[7:0] & m, e & m)
        rchk(12'h135, 32'h0);
        xfer(1'b1, 12'h151, 32'hFF);
        `CHK(n, w)
    endtask
    // ********************************
    // main sequence
    // ********************************
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rchk(12'h134, 32'h0004);
        rchk(12'h135, 32'h0);
        xfer(1'b1, 12'h200, 32'h1234);
        rchk(12'h200, 32'h0);
        xfer(1'b1, 12'h134, 32'hFFFF);
        rchk(12'h134, 32'h07B7);
        foreach (rv[j]) xfer(1'b1, 12'h136 + 12'(j), {16'h0, rv[j]});
        foreach (rv[j]) rchk(12'h136 + 12'(j), {16'h0, rv[j]});
        xfer(1'b1, 12'h152, 32'hF7);
        rchk(12'h152, 32'hF7);
        $display("test registers done");
        case_run(16'h0004, 0, 1'b1, 8'hFF, 8'h00, 0);
        case_run(16'h0084, 0, 1'b1, 8'hFF, 8'h04, 2);
        case_run(16'h0080, 0, 1'b1, 8'hFF, 8'h04, 0);
        case_run(16'h0080, 1, 1'b1, 8'hFF, 8'h10, 0);
        case_run(16'h0090, 1, 1'b1, 8'hFF, 8'h10, 2);
        case_run(16'h0080, 2, 1'b1, 8'hFF, 8'h02, 0);
        case_run(16'h0082, 2, 1'b1, 8'hFF, 8'h02, 2);
        case_run(16'h0080, 3, 1'b1, 8'hFF, 8'h01, 0);
        case_run(16'h00A1, 3, 1'b1, 8'hFF, 8'h01, 2);
        case_run(16'h00A1, 4, 1'b1, 8'h20, 8'h20, 0);
        case_run(16'h0081, 4, 1'b1, 8'h21, 8'h01, 2);
        case_run(16'h0084, 0, 1'b0, 8'h44, 8'h40, 0);
        case_run(16'h0080, 5, 1'b1, 8'hFF, 8'h80, 0);
        $display("test frame kinds done");
        foreach (plen[l]) case_run(16'h0084 | (16'(l) << 9), 0, 1'b1, 8'hFF, 8'h04, plen[l]);
        $display("test pulse lengths done");
        gap_v = 2;
        case_run(16'h0184, 0, 1'b1, 8'hFF, 8'h04, 20);
        `CHK(wake, 1'b1)
        xfer(1'b1, 12'h134, 32'h0984);
        repeat (3) @(posedge mclk);
        `CHK(wake, 1'b0)
        rchk(12'h134, 32'h0184);
        $display("test level style done");
        xfer(1'b1, 12'h152, 32'hFB);
        build(0);
        rx.send(fq, 1'b1, 0);
        repeat (4) @(posedge mclk);
        `CHK(irq, 1'b0)
        xfer(1'b1, 12'h152, 32'hF7);
        repeat (3) @(posedge mclk);
        `CHK(irq, 1'b1)
        xfer(1'b1, 12'h151, 32'hFF);
        repeat (3) @(posedge mclk);
        `CHK(irq, 1'b0)
        $display("test irq mask done");
        results();
    end
endmodule // wolf_filter_tb_top
`default_nettype wire
